// ===== hdl/dam_pkg.sv
/*
  Package for the drive alarm and warning supervisor: register map,
  field positions, reset values, alarm codes and indicator timing.
  Assumes a 50 MHz clock and a plain strobe register port.
*/
package dam_pkg;
  // ***********************************************************
  // Register offsets (byte addresses)
  // ***********************************************************
  localparam logic [7:0] DAM_REG_CTRL   = 8'h00;
  localparam logic [7:0] DAM_REG_STATUS = 8'h04;
  localparam logic [7:0] DAM_REG_OVTHR  = 8'h08;
  localparam logic [7:0] DAM_REG_UVTHR  = 8'h0C;
  localparam logic [7:0] DAM_REG_VMEAS  = 8'h10;

  // ***********************************************************
  // Field positions
  // ***********************************************************
  // CTRL: bit0 write 1 = serial alarm clear, bit1 = 48 V supply mode
  localparam int DAM_CTRL_CLR_BIT  = 0;
  localparam int DAM_CTRL_MODE_BIT = 1;
  // STATUS
  localparam int DAM_ST_OV_ALM_BIT  = 0;
  localparam int DAM_ST_CPU_ALM_BIT = 1;
  localparam int DAM_ST_HI_WRN_BIT  = 2;
  localparam int DAM_ST_LO_WRN_BIT  = 3;
  localparam int DAM_ST_MODE_BIT    = 4;
  localparam int DAM_ST_CODE_LSB    = 8;

  // ***********************************************************
  // Values: voltages in units of 0.1 V, alarm codes and blink counts
  // ***********************************************************
  localparam logic [9:0] DAM_THR_MIN      = 10'd140;
  localparam logic [9:0] DAM_THR_MAX      = 10'd630;
  localparam logic [9:0] DAM_UV_RESET     = 10'd140;
  localparam logic [9:0] DAM_OV_RESET     = 10'd630;
  localparam logic [9:0] DAM_OV_TRIP_24   = 10'd360;
  localparam logic [9:0] DAM_OV_TRIP_48   = 10'd630;
  localparam logic [7:0] DAM_CODE_OV      = 8'h22;
  localparam logic [7:0] DAM_CODE_CPU     = 8'h29;
  localparam logic [7:0] DAM_CODE_NONE    = 8'h00;
  localparam logic [3:0] DAM_BLINKS_OV    = 4'd3;
  localparam logic [3:0] DAM_BLINKS_CPU   = 4'd9;

  // ***********************************************************
  // Indicator timing
  // ***********************************************************
  localparam int DAM_CLK_HZ      = 50_000_000;
  localparam int DAM_BLINK_MS    = 200;
  localparam int DAM_BLINK_CYC   = DAM_CLK_HZ / 1000 * DAM_BLINK_MS;
  // Rest between red groups, in blink periods; longer than a gap so
  // an observer can tell where one count ends
  localparam int DAM_REST_PERIODS = 3;

  typedef enum logic [1:0] {
    DAM_LED_OFF = 2'b00,
    DAM_LED_ON  = 2'b01,
    DAM_LED_GAP = 2'b11,
    DAM_LED_REST = 2'b10
  } dam_led_t;
endpackage

// ===== hdl/dam_monitor.sv
/*
  Drive alarm and warning supervisor. Latches an overvoltage alarm
  and a processor peripheral fault, de-energises the motor, holds the
  brake, blinks the indicator red by alarm code and blue on warnings.
  Assumes synchronous inputs, a 10-bit supply measurement in 0.1 V
  units and that the register master keeps thresholds in range.
*/
// The address map and strobed register access were chosen for this implementation.
// Function
// - Any alarm stops motor operation at once.
// - Alarm active makes the indicator blink red from the alarm onset.
// - Alarm cuts motor winding current, holding force lost.
// - With alarm, brake stays in its holding state.
// - Clear input acts only on its rising edge.
// - Serial clear command also clears resettable alarms.
// - Power cycle, here reset, clears every alarm.
// - Overvoltage alarm, code 22h, three blinks, any clear method.
// - Processor fault alarm, code 29h, nine blinks, power cycle only.
// - Overvoltage trips above 36 V in 24 V mode, 63 V in 48 V mode.
// - Warnings raise below alarm level, independent of alarm latch.
// - Any warning makes the indicator blink blue while no alarm is active.
// - Supply-high warning sets above the high threshold.
// - Supply-high warning clears itself below the high threshold.
// - Supply-low warning sets under the low threshold.
// - Supply-low warning clears itself above the low threshold.
// - Thresholds range 140 to 630 in 0.1 V steps.
// - Low threshold loads 140 after reset.
`timescale 1ns/100ps
module dam_monitor
  import dam_pkg::*;
#(
  parameter int BLINK_CYC = DAM_BLINK_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Supply and fault sensing
  input  wire logic [9:0]  supply_meas_i,
  input  wire logic        cpu_fault_i,
  input  wire logic        alarm_clear_input_i,
  // Motor and indicator
  output logic             motor_run_en_o,
  output logic             winding_en_o,
  output logic             brake_release_o,
  output logic             led_red_o,
  output logic             led_blue_o,
  output logic             supply_high_warning_o,
  output logic             supply_low_warning_o
);

  initial begin
    if (BLINK_CYC < 4) $error("BLINK_CYC too small");
  end

  localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYC - 1);
  localparam logic [31:0] REST_LAST  = 32'(DAM_REST_PERIODS * BLINK_CYC - 1);

  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    logic        ov_alm;
    logic        cpu_alm;
    logic        hi_wrn;
    logic        lo_wrn;
    logic        mode48;
    logic        clr_in_d;
    logic [9:0]  ov_thr;
    logic [9:0]  uv_thr;
    logic [31:0] rdata;
    dam_led_t    led;
    logic [31:0] tmr;
    logic [3:0]  cnt;
    logic        red;
    logic        blue;
    logic        run;
  } dam_state_t;

  dam_state_t s_r;
  dam_state_t s_nxt;

  function automatic logic [3:0] blinks_of(input logic cpu, input logic ov);
    blinks_of = cpu ? DAM_BLINKS_CPU : (ov ? DAM_BLINKS_OV : 4'd1);
  endfunction

  logic       clr_edge;
  logic       ser_clr;
  logic       any_alm;
  logic       any_wrn;
  logic [9:0] trip;

  always_comb begin
    s_nxt    = s_r;
    clr_edge = alarm_clear_input_i && !s_r.clr_in_d;
    ser_clr  = reg_wr_i && reg_addr_i == DAM_REG_CTRL &&
               reg_wdata_i[DAM_CTRL_CLR_BIT];
    trip     = s_r.mode48 ? DAM_OV_TRIP_48 : DAM_OV_TRIP_24;
    s_nxt.clr_in_d = alarm_clear_input_i;

    // Clear first so a new trip in the same cycle wins
    if (clr_edge || ser_clr) begin
      s_nxt.ov_alm = 1'b0;
    end
    if (supply_meas_i > trip) begin
      s_nxt.ov_alm = 1'b1;
    end
    if (cpu_fault_i) begin
      s_nxt.cpu_alm = 1'b1;  // cleared only by reset
    end

    // Warnings follow the supply, no latch
    s_nxt.hi_wrn = supply_meas_i > s_r.ov_thr;
    s_nxt.lo_wrn = supply_meas_i < s_r.uv_thr;

    any_alm = s_nxt.ov_alm || s_nxt.cpu_alm;
    any_wrn = s_nxt.hi_wrn || s_nxt.lo_wrn;
    s_nxt.run = !any_alm;

    // Register writes; out-of-range thresholds are ignored
    if (reg_wr_i) begin
      case (reg_addr_i)
        DAM_REG_CTRL: begin
          s_nxt.mode48 = reg_wdata_i[DAM_CTRL_MODE_BIT];
        end
        DAM_REG_OVTHR: begin
          if (reg_wdata_i[9:0] >= DAM_THR_MIN &&
              reg_wdata_i[9:0] <= DAM_THR_MAX && reg_wdata_i[31:10] == '0)
            s_nxt.ov_thr = reg_wdata_i[9:0];
        end
        DAM_REG_UVTHR: begin
          if (reg_wdata_i[9:0] >= DAM_THR_MIN &&
              reg_wdata_i[9:0] <= DAM_THR_MAX && reg_wdata_i[31:10] == '0)
            s_nxt.uv_thr = reg_wdata_i[9:0];
        end
        default: begin
        end
      endcase
    end

    // Read data valid in the cycle after the strobe only
    s_nxt.rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        DAM_REG_CTRL:   s_nxt.rdata = {30'h0, s_r.mode48, 1'b0};
        DAM_REG_STATUS: s_nxt.rdata = {16'h0,
            (s_r.cpu_alm ? DAM_CODE_CPU :
             (s_r.ov_alm ? DAM_CODE_OV : DAM_CODE_NONE)),
            3'h0, s_r.mode48, s_r.lo_wrn, s_r.hi_wrn,
            s_r.cpu_alm, s_r.ov_alm};
        DAM_REG_OVTHR:  s_nxt.rdata = {22'h0, s_r.ov_thr};
        DAM_REG_UVTHR:  s_nxt.rdata = {22'h0, s_r.uv_thr};
        DAM_REG_VMEAS:  s_nxt.rdata = {22'h0, supply_meas_i};
        default:        s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // ***********************************************************
    // Indicator: alarms blink N red pulses then rest; warning blinks
    // blue continuously. A fresh alarm restarts the sequence so the
    // red light comes on at the alarm onset.
    // ***********************************************************
    s_nxt.tmr = s_r.tmr + 32'd1;
    if (any_alm && !(s_r.ov_alm || s_r.cpu_alm)) begin
      s_nxt.led = DAM_LED_ON;
      s_nxt.tmr = 32'd0;
      s_nxt.cnt = blinks_of(s_nxt.cpu_alm, s_nxt.ov_alm);
    end else if (!any_alm && !any_wrn) begin
      s_nxt.led = DAM_LED_OFF;
      s_nxt.tmr = 32'd0;
    end else if (s_r.led == DAM_LED_OFF) begin
      s_nxt.led = DAM_LED_ON;
      s_nxt.tmr = 32'd0;
      s_nxt.cnt = blinks_of(s_nxt.cpu_alm, s_nxt.ov_alm);
    end else if (s_r.tmr >= (s_r.led == DAM_LED_REST ?
                             REST_LAST : BLINK_LAST)) begin
      s_nxt.tmr = 32'd0;
      case (s_r.led)
        DAM_LED_ON: begin
          s_nxt.led = (any_alm && s_r.cnt <= 4'd1) ?
                      DAM_LED_REST : DAM_LED_GAP;
          s_nxt.cnt = s_r.cnt - 4'd1;
        end
        DAM_LED_GAP: begin
          s_nxt.led = DAM_LED_ON;
          if (!any_alm) s_nxt.cnt = 4'd1;
        end
        DAM_LED_REST: begin
          s_nxt.led = DAM_LED_ON;
          s_nxt.cnt = blinks_of(s_nxt.cpu_alm, s_nxt.ov_alm);
        end
        default: s_nxt.led = DAM_LED_OFF;
      endcase
    end
    s_nxt.red  = any_alm && s_nxt.led == DAM_LED_ON;
    s_nxt.blue = !any_alm && any_wrn &&
                 s_nxt.led == DAM_LED_ON;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r          <= '0;
      s_r.ov_thr   <= DAM_OV_RESET;
      s_r.uv_thr   <= DAM_UV_RESET;
      s_r.led      <= DAM_LED_OFF;
      s_r.run      <= 1'b1;
      s_r.clr_in_d <= 1'b1;  // Level high at reset is no edge
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_o           = s_r.rdata;
  assign motor_run_en_o        = s_r.run;
  assign winding_en_o          = s_r.run;
  assign brake_release_o       = s_r.run;
  assign led_red_o             = s_r.red;
  assign led_blue_o            = s_r.blue;
  assign supply_high_warning_o = s_r.hi_wrn;
  assign supply_low_warning_o  = s_r.lo_wrn;

  // ***********************************************************
  // Checks
  // ***********************************************************
  AST_STOP_ON_ALARM: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_r.ov_alm || s_r.cpu_alm) |-> !motor_run_en_o)
    else $error("motor running with alarm");
  AST_WINDING_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(s_r.ov_alm || s_r.cpu_alm) |-> !winding_en_o)
    else $error("winding on after alarm");
  AST_BRAKE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !winding_en_o |-> !brake_release_o)
    else $error("brake released while de-energised");
  AST_RED_ONSET: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(s_r.ov_alm || s_r.cpu_alm) |-> led_red_o)
    else $error("red not on at alarm onset");
  AST_LEVEL_NO_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_r.ov_alm && alarm_clear_input_i && $past(alarm_clear_input_i)
     && !reg_wr_i) |=> s_r.ov_alm)
    else $error("alarm cleared by level");
  AST_EDGE_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    (alarm_clear_input_i && !s_r.clr_in_d && supply_meas_i <= DAM_OV_TRIP_24)
    |=> !s_r.ov_alm)
    else $error("edge did not clear overvoltage");
  AST_CPU_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.cpu_alm |=> s_r.cpu_alm)
    else $error("processor alarm cleared without reset");
  AST_TRIP_24: assert property (@(posedge clk_i) disable iff (rst_i)
    (!s_r.mode48 && supply_meas_i > DAM_OV_TRIP_24) |=> s_r.ov_alm)
    else $error("no trip above 36 V");
  AST_HIGH_WARN: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> supply_high_warning_o ==
             ($past(supply_meas_i) > $past(s_r.ov_thr)))
    else $error("high warning mismatch");
  AST_LOW_WARN: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> supply_low_warning_o ==
             ($past(supply_meas_i) < $past(s_r.uv_thr)))
    else $error("low warning mismatch");
  AST_RED_PRIO: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_r.ov_alm || s_r.cpu_alm) |-> !led_blue_o)
    else $error("blue shown during alarm");
  AST_THR_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.uv_thr >= DAM_THR_MIN && s_r.uv_thr <= DAM_THR_MAX)
    else $error("low threshold out of range");
endmodule

// ===== sim/dam_plant.sv
/*
  Far-side model: supply level, fault source, clear input and an
  indicator observer that counts red blinks per group and blue rises.
  Assumes the bench calls its tasks right after a rising clock edge.
*/
`timescale 1ns/100ps
module dam_plant #(
  parameter int BLINK_CYC = 8
) (
  // Clock
  input  wire logic       clk_i,
  // Indicator
  input  wire logic       led_red_i,
  input  wire logic       led_blue_i,
  // Plant drive
  output logic      [9:0] supply_meas_o,
  output logic            cpu_fault_o,
  output logic            clear_o,
  // Observations
  output int              red_group_o,
  output int              blue_rise_o
);
  int   red_cnt;
  int   low_run;
  logic red_q;
  logic blue_q;

  initial begin
    supply_meas_o = 10'h0FA;
    cpu_fault_o   = 1'b0;
    clear_o       = 1'b0;
    red_group_o   = 0;
    blue_rise_o   = 0;
    red_cnt       = 0;
    low_run       = 0;
    red_q         = 1'b0;
    blue_q        = 1'b0;
  end

  // A dark spell longer than one gap closes a blink group
  always @(posedge clk_i) begin
    red_q  <= led_red_i;
    blue_q <= led_blue_i;
    if (led_blue_i && !blue_q) blue_rise_o <= blue_rise_o + 1;
    if (led_red_i && !red_q) red_cnt <= red_cnt + 1;
    low_run <= led_red_i ? 0 : low_run + 1;
    if (!led_red_i && low_run == BLINK_CYC && red_cnt != 0) begin
      red_group_o <= red_cnt;
      red_cnt     <= 0;
    end
  end

  task automatic set_meas(input logic [9:0] v);
    supply_meas_o <= v;
  endtask
  task automatic set_fault(input logic v);
    cpu_fault_o <= v;
  endtask
  // Clear requests are made as level changes; the edge is what counts
  task automatic set_clear(input logic v);
    clear_o <= v;
  endtask
endmodule

// ===== sim/dam_monitor_test.sv
/*
  Self-checking bench for the alarm and warning supervisor.
  Assumes a short blink period parameter and the plain strobe port.
*/
`timescale 1ns/100ps
module dam_monitor_test
  import dam_pkg::*;
;
  localparam int BC = 8;
  logic        clk, rst, wr, rd;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [9:0]  meas;
  logic        fault, clr, run, wind, brk, red, blue, hi, lo;
  int          fail_count, samples_checked, b;

  dam_monitor #(.BLINK_CYC(BC)) u_dut (
    .clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .supply_meas_i(meas), .cpu_fault_i(fault),
    .alarm_clear_input_i(clr), .motor_run_en_o(run),
    .winding_en_o(wind), .brake_release_o(brk), .led_red_o(red),
    .led_blue_o(blue), .supply_high_warning_o(hi),
    .supply_low_warning_o(lo));
  dam_plant #(.BLINK_CYC(BC)) u_plant (
    .clk_i(clk), .led_red_i(red), .led_blue_i(blue),
    .supply_meas_o(meas), .cpu_fault_o(fault), .clear_o(clr),
    .red_group_o(), .blue_rise_o());

  always #10 clk = ~clk;

  // ***********************************************************
  // Access and compare tasks
  // ***********************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Flags are {mode48, low, high, cpu alarm, ov alarm}
  function automatic logic [31:0] st(input logic [4:0] f,
                                     input logic [7:0] c);
    return {16'h0000, c, 3'b000, f};
  endfunction
  task automatic mv(input logic [9:0] v);
    @(posedge clk);
    u_plant.set_meas(v);
    repeat (3) @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] outs();
    return {27'h0, run, wind, brk, red, blue};
  endfunction
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test;
  end

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  initial begin
    fail_count = 0; samples_checked = 0; clk = 0; rst = 1;
    addr = 8'h00; wdata = 32'h0; wr = 0; rd = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_chk(DAM_REG_UVTHR, 32'h0000_008C);
    chk(outs(), 32'h0000_001C);
    wr_reg(DAM_REG_UVTHR, 32'h0000_0064);
    rd_chk(DAM_REG_UVTHR, 32'h0000_008C);
    wr_reg(DAM_REG_UVTHR, 32'h0000_00C8);
    wr_reg(DAM_REG_OVTHR, 32'h0000_012C);
    mv(10'h136);
    rd_chk(DAM_REG_STATUS, st(5'h04, 8'h00));
    b = u_plant.blue_rise_o;
    repeat (40) @(posedge clk);
    chk({31'h0, u_plant.blue_rise_o > b}, 32'h1);
    chk(outs() & 32'h1C, 32'h1C);
    mv(10'h122);
    rd_chk(DAM_REG_STATUS, st(5'h00, 8'h00));
    mv(10'h096);
    rd_chk(DAM_REG_STATUS, st(5'h08, 8'h00));
    mv(10'h0FA);
    rd_chk(DAM_REG_STATUS, st(5'h00, 8'h00));
    mv(10'h168);
    rd_chk(DAM_REG_STATUS, st(5'h04, 8'h00));
    mv(10'h169);
    chk(outs(), 32'h0000_0002);
    rd_chk(DAM_REG_STATUS, st(5'h05, 8'h22));
    b = u_plant.blue_rise_o;
    repeat (60) @(posedge clk);
    chk(u_plant.blue_rise_o - b, 32'h0);
    chk(u_plant.red_group_o, 32'h3);
    mv(10'h0FA);
    rd_chk(DAM_REG_STATUS, st(5'h01, 8'h22));
    @(posedge clk);
    u_plant.set_clear(1'b1);
    rd_chk(DAM_REG_STATUS, st(5'h00, 8'h00));
    chk(outs() & 32'h1C, 32'h1C);
    // Clear held high must not clear a fresh alarm
    mv(10'h169);
    mv(10'h0FA);
    rd_chk(DAM_REG_STATUS, st(5'h01, 8'h22));
    u_plant.set_clear(1'b0);
    wr_reg(DAM_REG_CTRL, 32'h0000_0001);
    rd_chk(DAM_REG_STATUS, st(5'h00, 8'h00));
    wr_reg(DAM_REG_CTRL, 32'h0000_0002);
    mv(10'h276);
    rd_chk(DAM_REG_STATUS, st(5'h14, 8'h00));
    mv(10'h277);
    rd_chk(DAM_REG_STATUS, st(5'h15, 8'h22));
    mv(10'h0FA);
    wr_reg(DAM_REG_CTRL, 32'h0000_0003);
    rd_chk(DAM_REG_STATUS, st(5'h10, 8'h00));
    // Let the observer close the cut group before the next alarm
    repeat (12) @(posedge clk);
    u_plant.set_fault(1'b1);
    repeat (3) @(posedge clk);
    u_plant.set_fault(1'b0);
    #1 chk(outs() & 32'h1C, 32'h0);
    rd_chk(DAM_REG_STATUS, st(5'h12, 8'h29));
    repeat (170) @(posedge clk);
    chk(u_plant.red_group_o, 32'h9);
    u_plant.set_clear(1'b1);
    wr_reg(DAM_REG_CTRL, 32'h0000_0003);
    rd_chk(DAM_REG_STATUS, st(5'h12, 8'h29));
    // Power cycle stands for the only way out of the fault
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(DAM_REG_STATUS, st(5'h00, 8'h00));
    rd_chk(DAM_REG_UVTHR, 32'h0000_008C);
    chk(outs(), 32'h0000_001C);
    finish_test;
  end
endmodule
